// ### dv/periodic_timer_16bit_tb.sv
// Self-checking bench for the periodic timer
`timescale 1ns/10ps
`default_nettype none
module periodic_timer_16bit_tb
	import ptimer_pkg::*;
;
	localparam int TA_DIV = 3;
	localparam int EV_DIV = 5;
	int mult [4] = '{1, 2, TA_DIV, EV_DIV};
	logic clk = 1'b0;
	logic arst_n = 1'b0;
	logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, port_out = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0000_0000;
	logic [3:0] pstrb = 4'h0;
	logic [31:0] prdata, rv;
	logic pready, pslverr, ta_tick, ev_tick, pin, cap_ev, cap_irq, re;
	int n_fail = 0;
	int checked = 0;
	always #5 clk = ~clk;
	ptimer_tick_model #(.TA_DIV(TA_DIV), .EV_DIV(EV_DIV)) i_far (.core_clk_i(clk), .arst_n_i(arst_n),
		.type_a_timer_clock_o(ta_tick), .event_tick_o(ev_tick));
	periodic_timer_16bit i_dut (.core_clk_i(clk), .arst_n_i(arst_n), .psel_i(psel), .penable_i(penable),
		.pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .pstrb_i(pstrb), .prdata_o(prdata),
		.pready_o(pready), .pslverr_o(pslverr), .type_a_timer_clock_i(ta_tick), .event_tick_i(ev_tick),
		.port_out_i(port_out), .pin_o(pin), .capture_event_o(cap_ev), .capture_irq_o(cap_irq));
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			n_fail++;
			$display("mismatch at %0t got %h exp %h", $time, got, exp);
		end
	endtask
	// One APB transfer, held until pready is seen at a rising edge
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		pstrb <= 4'hf;
		@(posedge clk);
		penable <= 1'b1;
		@(posedge clk);
		while (pready !== 1'b1) @(posedge clk);
		rv = prdata;
		re = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask
	task automatic rdc(input logic [11:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0);
		chk(rv, exp);
	endtask
	// Cycles until the next capture pulse, sampled away from the edge
	task automatic wev(output int n);
		n = 0;
		do begin
			@(negedge clk);
			n++;
		end while (cap_ev !== 1'b1);
	endtask
	task automatic cfg(input logic [15:0] top, input int sel);
		wr(ADDR_CONTROL, RDATA_ZERO);
		wr(ADDR_STATUS, 32'h1);
		wr(ADDR_COMPARE, {16'h0, top});
		wr(ADDR_OUTPUT, 32'h1);
		wr(ADDR_CONTROL, 32'(sel << CTRL_CLOCK_SELECT_LSB) | 32'h1);
	endtask
	task automatic close_out();
		$display("checked %0d n_fail %0d", checked, n_fail);
		if (n_fail == 0 && checked > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask
	// Main sequence
	initial begin
		int n, l0;
		logic pv;
		logic [31:0] r1;
		repeat (12) @(posedge clk);
		arst_n <= 1'b1;
		port_out <= 1'b1;
		repeat (3) @(posedge clk);
		rdc(ADDR_CONTROL, RDATA_ZERO);
		rdc(ADDR_COUNT, {16'h0, COUNT_BOTTOM});
		rdc(ADDR_COMPARE, {16'h0, COMPARE_RESET});
		rdc(ADDR_STATUS, RDATA_ZERO);
		chk({31'h0, pin}, 32'h1);
		rdc(12'h014, RDATA_ZERO);
		chk({31'h0, re}, 32'h1);
		$display("test reset done");
		for (int s = 0; s < 4; s++) begin
			cfg(16'h0003, s);
			wev(n);
			pv = pin;
			wev(n);
			chk(n, mult[s] * 4);
			chk({31'h0, pin}, {31'h0, ~pv});
		end
		chk({31'h0, cap_irq}, 32'h1);
		rdc(ADDR_STATUS, 32'h3);
		wr(ADDR_CONTROL, RDATA_ZERO);
		wr(ADDR_STATUS, 32'h1);
		rdc(ADDR_STATUS, RDATA_ZERO);
		// Stopped: the pin shows the idle level, not the port value
		wr(ADDR_OUTPUT, 32'h3);
		rdc(ADDR_OUTPUT, 32'h3);
		@(negedge clk);
		chk({31'h0, pin}, 32'h1);
		wr(ADDR_OUTPUT, 32'h1);
		rdc(ADDR_OUTPUT, 32'h1);
		@(negedge clk);
		chk({31'h0, pin}, 32'h0);
		$display("test period done");
		cfg(16'hffff, 0);
		apb(1'b0, ADDR_COUNT, 32'h0);
		r1 = rv;
		rdc(ADDR_COUNT, r1 + 32'h3);
		for (int k = 0; k < 2; k++) begin
			wr(ADDR_CONTROL, RDATA_ZERO);
			wr(ADDR_COUNT, k ? 32'hfff0 : 32'h0);
			cfg(16'h0005, 0);
			wev(n);
			l0 = k ? l0 : n;
		end
		chk(n - l0, 32'h10);
		$display("test wrap done");
		close_out();
	end
	// Watchdog
	initial begin
		repeat (5000) @(posedge clk);
		n_fail++;
		close_out();
	end
endmodule
`default_nettype wire

// ### dv/ptimer_asserts.sv
// Checker for APB answers, capture outputs and pin selection
`timescale 1ns/10ps
`default_nettype none
module ptimer_asserts
	import ptimer_pkg::*;
#(
	parameter int CNT_W = COUNT_W
) (
	input wire logic core_clk_i,
	input wire logic arst_n_i,
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [11:0] paddr_i,
	input wire logic [31:0] pwdata_i,
	input wire logic [3:0] pstrb_i,
	input wire logic [31:0] prdata_o,
	input wire logic pready_o,
	input wire logic pslverr_o,
	input wire logic port_out_i,
	input wire logic pin_o,
	input wire logic capture_event_o,
	input wire logic capture_irq_o
);
	default clocking cb @(posedge core_clk_i); endclocking
	default disable iff (!arst_n_i);
	// Access decode, mirrored from the bus only
	wire logic acc = psel_i && penable_i;
	wire logic mapped = paddr_i inside {ADDR_CONTROL, ADDR_OUTPUT, ADDR_STATUS, ADDR_COUNT, ADDR_COMPARE};
	wire logic wr0 = acc && pwrite_i && pstrb_i[0];
	wire logic clr = wr0 && paddr_i == ADDR_STATUS && pwdata_i[STAT_CAPTURE_BIT];
	logic en;
	logic woe;
	// Shadow of enable and output enable, so pin choice is judged from writes
	always_ff @(posedge core_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			en <= 1'b0;
			woe <= 1'b0;
		end else begin
			en <= (wr0 && paddr_i == ADDR_CONTROL) ? pwdata_i[CTRL_ENABLE_BIT] : en;
			woe <= (wr0 && paddr_i == ADDR_OUTPUT) ? pwdata_i[OUT_WOE_BIT] : woe;
		end
	end
	// Irq may rise one cycle before or with the event pulse
	sequence s_event_soon;
		##[0:1] capture_event_o;
	endsequence
	a_ready_high: assert property (pready_o) else $error("pready low");
	a_err_unmapped: assert property (acc && !mapped |-> pslverr_o) else $error("no slverr");
	a_err_mapped: assert property (acc && mapped |-> !pslverr_o) else $error("bad slverr");
	a_err_rdzero: assert property (acc && !pwrite_i && !mapped |-> prdata_o == RDATA_ZERO) else $error("rdata");
	a_irq_sticky: assert property (capture_irq_o && !clr |=> capture_irq_o) else $error("irq lost");
	a_irq_cause: assert property ($rose(capture_irq_o) |-> s_event_soon) else $error("irq no event");
	a_event_irq: assert property (capture_event_o |-> ##[0:1] capture_irq_o) else $error("event no irq");
	a_event_enabled: assert property (capture_event_o |-> $past(en) || $past(en, 2) || $past(en, 3))
		else $error("event while off");
	a_pin_port: assert property (!woe |-> pin_o == port_out_i) else $error("pin not port");
endmodule
bind periodic_timer_16bit ptimer_asserts #(.CNT_W(CNT_W)) i_asserts (.core_clk_i(core_clk_i),
	.arst_n_i(arst_n_i), .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
	.pwdata_i(pwdata_i), .pstrb_i(pstrb_i), .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
	.port_out_i(port_out_i), .pin_o(pin_o), .capture_event_o(capture_event_o), .capture_irq_o(capture_irq_o));
`default_nettype wire

// ### dv/ptimer_tick_model.sv
// Far-side tick sources: type-A timer clock enable and event channel
`timescale 1ns/10ps
`default_nettype none
module ptimer_tick_model #(
	parameter int TA_DIV = 3,
	parameter int EV_DIV = 5
) (
	// Clock and reset
	input wire logic core_clk_i,
	input wire logic arst_n_i,
	// Tick pulses
	output logic type_a_timer_clock_o,
	output logic event_tick_o
);
	int ta_cnt;
	int ev_cnt;
	// Free running dividers, one-cycle pulse at the last count
	always_ff @(posedge core_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			ta_cnt <= 0;
			ev_cnt <= 0;
		end else begin
			ta_cnt <= (ta_cnt == TA_DIV - 1) ? 0 : ta_cnt + 1;
			ev_cnt <= (ev_cnt == EV_DIV - 1) ? 0 : ev_cnt + 1;
		end
	end
	assign type_a_timer_clock_o = (ta_cnt == TA_DIV - 1);
	assign event_tick_o = (ev_cnt == EV_DIV - 1);
endmodule
`default_nettype wire

// ### src/periodic_timer_16bit.sv
// Sixteen-bit periodic interrupt timer with APB register slave
//
// The register offsets and the APB interface to the registers were decided locally.
`timescale 1ns/10ps
`default_nettype none
// Contract
// RULE1: Periodic interrupt mode is the only mode, active straight from reset.
// RULE2: Count equal to compare value raises capture interrupt and capture event.
// RULE3: Compare set below count: keep counting to 0xffff, then wrap.
// RULE4: Counter is 16 bits; bottom is 0x0000, maximum 0xffff.
// RULE5: Waveform output enable makes waveform override port value on pin.
// RULE6: Writing enable to one starts counting selected prescaled clock ticks.
// RULE7: Counter clock comes from peripheral clock or type-A timer clock.
// RULE8: Clock select picks one prescaler output directly as counter clock.
// RULE9: With type-A clock selected, count in step with that timer.
// RULE10: Configuring party selects event channel clock for event-controlled operation.
// RULE11: Software writes compare, optionally output enable, then enable last.
// RULE12: Reading the count register returns the live counter value.
// RULE13: After reaching compare value the count restarts from zero.
// RULE14: Compare is checked on every active counter tick while enabled.
module periodic_timer_16bit
	import ptimer_pkg::*;
#(
	parameter int CNT_W = COUNT_W
) (
	// Clock and reset
	input wire logic core_clk_i,
	input wire logic arst_n_i,
	// APB slave
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [11:0] paddr_i,
	input wire logic [31:0] pwdata_i,
	input wire logic [3:0] pstrb_i,
	output logic [31:0] prdata_o,
	output logic pready_o,
	output logic pslverr_o,
	// Tick sources
	input wire logic type_a_timer_clock_i,
	input wire logic event_tick_i,
	// Pin and port
	input wire logic port_out_i,
	output logic pin_o,
	// Events and interrupt
	output logic capture_event_o,
	output logic capture_irq_o
);
	// ------------------------------------------------------------
	// Reset release
	// ------------------------------------------------------------
	logic rst_meta;
	logic rst_n;

	// Async assert, two-stage synchronous release
	always_ff @(posedge core_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			rst_meta <= 1'b0;
			rst_n <= 1'b0;
		end else begin
			rst_meta <= 1'b1;
			rst_n <= rst_meta;
		end
	end

	// ------------------------------------------------------------
	// State
	// ------------------------------------------------------------
	// One-hot run states; the other two codes only come from an upset
	typedef enum logic [1:0] {
		ST_IDLE = 2'b01,
		ST_RUN = 2'b10
	} run_state_type;

	run_state_type state;
	run_state_type next_state;
	logic enable;
	logic [1:0] clock_select;
	logic waveform_output_enable;
	logic waveform_level;
	logic [CNT_W-1:0] count_value;
	logic [CNT_W-1:0] next_count_value;
	logic [CNT_W-1:0] compare_capture_value;
	logic capture_flag;
	logic waveform_out;
	logic next_waveform_out;
	logic counter_clock;
	logic top_hit;
	logic at_max;
	logic capture_pulse;
	logic capture_event;
	logic wrap_tick;
	logic running;

	// ------------------------------------------------------------
	// APB decode
	// ------------------------------------------------------------
	logic access;
	logic wr;
	logic wr_control;
	logic wr_output;
	logic wr_status;
	logic wr_count;
	logic wr_compare;
	logic mapped;
	logic sel_control;
	logic sel_output;
	logic sel_status;
	logic sel_count;
	logic sel_compare;
	logic [31:0] next_rdata;

	// Address match used for every register
	function automatic logic hit(input logic [11:0] addr, input logic [11:0] reg_addr);
		hit = (addr == reg_addr);
	endfunction

	// Zero-wait slave: every access completes in its first access cycle
	assign access = psel_i & penable_i;
	assign wr = access & pwrite_i;
	// Register selects, shared by the write strobes and the read mux
	assign sel_control = hit(paddr_i, ADDR_CONTROL);
	assign sel_output = hit(paddr_i, ADDR_OUTPUT);
	assign sel_status = hit(paddr_i, ADDR_STATUS);
	assign sel_count = hit(paddr_i, ADDR_COUNT);
	assign sel_compare = hit(paddr_i, ADDR_COMPARE);
	assign mapped = sel_control | sel_output | sel_status | sel_count | sel_compare;
	// Narrow registers sit in byte lane 0, so only that strobe matters
	assign wr_control = wr & sel_control & pstrb_i[0];
	assign wr_output = wr & sel_output & pstrb_i[0];
	assign wr_status = wr & sel_status & pstrb_i[0];
	assign wr_count = wr & sel_count;
	assign wr_compare = wr & sel_compare;
	assign pready_o = 1'b1;
	assign pslverr_o = access & ~mapped;

	// Read mux, registered so data comes from flip-flops
	always_comb begin
		next_rdata = RDATA_ZERO;
		if (sel_control) begin
			next_rdata[CTRL_ENABLE_BIT] = enable;
			next_rdata[CTRL_CLOCK_SELECT_LSB +: CLOCK_SELECT_W] = clock_select;
		end else if (sel_output) begin
			next_rdata[OUT_WOE_BIT] = waveform_output_enable;
			next_rdata[OUT_LEVEL_BIT] = waveform_level;
		end else if (sel_status) begin
			next_rdata[STAT_CAPTURE_BIT] = capture_flag;
			next_rdata[STAT_RUNNING_BIT] = running;
		end else if (sel_count) begin
			next_rdata[CNT_W-1:0] = count_value; // RULE12
		end else if (sel_compare) begin
			next_rdata[CNT_W-1:0] = compare_capture_value;
		end
	end

	// Read data captured in setup so it is stable in the access cycle
	always_ff @(posedge core_clk_i or negedge rst_n) begin
		if (!rst_n) begin
			prdata_o <= RDATA_ZERO;
		end else if (psel_i & ~penable_i & ~pwrite_i) begin
			prdata_o <= next_rdata;
		end
	end

	// ------------------------------------------------------------
	// Control registers
	// ------------------------------------------------------------
	// No mode field exists: reset state is already periodic mode
	always_ff @(posedge core_clk_i or negedge rst_n) begin
		if (!rst_n) begin
			enable <= 1'b0; // RULE1
			clock_select <= CLOCK_SELECT_DIV1;
		end else if (wr_control) begin
			enable <= pwdata_i[CTRL_ENABLE_BIT]; // RULE6
			clock_select <= pwdata_i[CTRL_CLOCK_SELECT_LSB +: CLOCK_SELECT_W];
		end
	end

	// Pin override and the level the waveform rests at while stopped
	always_ff @(posedge core_clk_i or negedge rst_n) begin
		if (!rst_n) begin
			waveform_output_enable <= 1'b0;
			waveform_level <= 1'b0;
		end else if (wr_output) begin
			waveform_output_enable <= pwdata_i[OUT_WOE_BIT]; // RULE5
			waveform_level <= pwdata_i[OUT_LEVEL_BIT];
		end
	end

	// Compare value, written a byte lane at a time
	always_ff @(posedge core_clk_i or negedge rst_n) begin
		if (!rst_n) begin
			compare_capture_value <= COMPARE_RESET;
		end else if (wr_compare) begin
			if (pstrb_i[0]) begin
				compare_capture_value[7:0] <= pwdata_i[7:0];
			end
			if (pstrb_i[1]) begin
				compare_capture_value[CNT_W-1:8] <= pwdata_i[CNT_W-1:8];
			end
		end
	end

	// ------------------------------------------------------------
	// Tick source
	// ------------------------------------------------------------
	ptimer_tick u_tick (
		.core_clk_i(core_clk_i),
		.rst_n_i(rst_n),
		.enable_i(enable),
		.clock_select_i(clock_select),
		.type_a_timer_clock_i(type_a_timer_clock_i),
		.event_tick_i(event_tick_i),
		.counter_clock_o(counter_clock)
	);

	// ------------------------------------------------------------
	// Run state
	// ------------------------------------------------------------
	// Running follows the enable bit one cycle later
	always_comb begin
		next_state = state;
		unique case (state)
			ST_IDLE: begin
				if (enable) begin
					next_state = ST_RUN; // RULE6
				end
			end
			ST_RUN: begin
				if (!enable) begin
					next_state = ST_IDLE;
				end
			end
			default: begin
				next_state = ST_IDLE;
			end
		endcase
	end

	// ------------------------------------------------------------
	// Counter
	// ------------------------------------------------------------
	// Only equality counts, so a compare below the count passes unseen until wrap
	assign top_hit = counter_clock & (count_value == compare_capture_value); // RULE14
	assign at_max = (count_value == COUNT_MAX); // RULE4
	assign wrap_tick = counter_clock & at_max; // RULE3
	assign capture_pulse = top_hit; // RULE2
	// Status and waveform both key off the registered run state
	assign running = (state == ST_RUN);

	// Software write wins over counting, matching a live reload
	always_comb begin
		next_count_value = count_value;
		if (wr_count) begin
			next_count_value = pwdata_i[CNT_W-1:0];
		end else if (top_hit) begin
			next_count_value = COUNT_BOTTOM; // RULE13
		end else if (wrap_tick) begin
			next_count_value = COUNT_BOTTOM; // RULE3
		end else if (counter_clock) begin
			next_count_value = count_value + COUNT_STEP; // RULE4
		end
	end

	// Run state and count; the count holds its value while stopped
	always_ff @(posedge core_clk_i or negedge rst_n) begin
		if (!rst_n) begin
			state <= ST_IDLE;
			count_value <= COUNT_BOTTOM;
		end else begin
			state <= next_state;
			count_value <= next_count_value;
		end
	end

	// Waveform toggles on each period, giving a square wave at half rate
	assign next_waveform_out = running ? (waveform_out ^ capture_pulse) : waveform_level;

	// Event leaves as a registered one-cycle pulse, free of decode glitches
	always_ff @(posedge core_clk_i or negedge rst_n) begin
		if (!rst_n) begin
			waveform_out <= 1'b0;
			capture_event <= 1'b0;
		end else begin
			waveform_out <= next_waveform_out;
			capture_event <= capture_pulse; // RULE2
		end
	end

	// Sticky capture flag, cleared by writing one; a new hit beats the clear
	always_ff @(posedge core_clk_i or negedge rst_n) begin
		if (!rst_n) begin
			capture_flag <= 1'b0;
		end else if (capture_pulse) begin
			capture_flag <= 1'b1; // RULE2
		end else if (wr_status & pwdata_i[STAT_CAPTURE_BIT]) begin
			capture_flag <= 1'b0;
		end
	end

	// ------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------
	// Pin mux stays combinational so the override acts at once
	assign capture_event_o = capture_event;
	assign capture_irq_o = capture_flag;
	assign pin_o = waveform_output_enable ? waveform_out : port_out_i; // RULE5

endmodule
`default_nettype wire

// ### src/ptimer_pkg.sv
// Package with register map, field layout and constants of the periodic timer
package ptimer_pkg;

	// ------------------------------------------------------------
	// Register map (byte addresses, one aligned word each)
	// ------------------------------------------------------------
	localparam logic [11:0] ADDR_CONTROL = 12'h000;
	localparam logic [11:0] ADDR_OUTPUT = 12'h004;
	localparam logic [11:0] ADDR_STATUS = 12'h008;
	localparam logic [11:0] ADDR_COUNT = 12'h00c;
	localparam logic [11:0] ADDR_COMPARE = 12'h010;

	// ------------------------------------------------------------
	// Field positions
	// ------------------------------------------------------------
	localparam int CTRL_ENABLE_BIT = 0;
	localparam int CTRL_CLOCK_SELECT_LSB = 1;
	localparam int CLOCK_SELECT_W = 2;
	localparam int OUT_WOE_BIT = 0;
	localparam int OUT_LEVEL_BIT = 1;
	localparam int STAT_CAPTURE_BIT = 0;
	localparam int STAT_RUNNING_BIT = 1;

	// ------------------------------------------------------------
	// Counter bounds and reset values
	// ------------------------------------------------------------
	localparam int COUNT_W = 16;
	localparam logic [15:0] COUNT_BOTTOM = 16'h0000;
	localparam logic [15:0] COUNT_MAX = 16'hffff;
	localparam logic [15:0] COUNT_STEP = 16'h0001;
	localparam logic [15:0] COMPARE_RESET = 16'h0000;
	localparam logic [31:0] RDATA_ZERO = 32'h0000_0000;

	// ------------------------------------------------------------
	// Clock select codes
	// ------------------------------------------------------------
	typedef enum logic [1:0] {
		CLOCK_SELECT_DIV1 = 2'h0,
		CLOCK_SELECT_DIV2 = 2'h1,
		CLOCK_SELECT_TYPE_A = 2'h2,
		CLOCK_SELECT_EVENT = 2'h3
	} clock_select_type;

	localparam int PRESCALE_DIV2_MAX = 1;

endpackage

// ### src/ptimer_tick.sv
// Counter clock tick generator: prescaler and clock select
`timescale 1ns/10ps
`default_nettype none
module ptimer_tick
	import ptimer_pkg::*;
(
	// Clock and reset
	input wire logic core_clk_i,
	input wire logic rst_n_i,
	// Control
	input wire logic enable_i,
	input wire logic [1:0] clock_select_i,
	// Tick sources
	input wire logic type_a_timer_clock_i,
	input wire logic event_tick_i,
	// Counter clock enable
	output logic counter_clock_o
);
	logic prescale;
	logic next_prescale;
	logic type_a_sel;
	logic event_sel;
	logic div2_sel;
	logic div1_sel;

	// ------------------------------------------------------------
	// Prescaler, restarted while disabled so first tick is aligned
	// ------------------------------------------------------------
	assign next_prescale = enable_i ? ~prescale : 1'b0;

	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			prescale <= 1'b0;
		end else begin
			prescale <= next_prescale;
		end
	end

	// One prescaler output routed straight through, no further division
	assign div1_sel = (clock_select_i == CLOCK_SELECT_DIV1); // RULE8
	assign div2_sel = (clock_select_i == CLOCK_SELECT_DIV2);
	assign type_a_sel = (clock_select_i == CLOCK_SELECT_TYPE_A);
	assign event_sel = (clock_select_i == CLOCK_SELECT_EVENT);
	// Type-A ticks are used as is, keeping both timers in lockstep
	assign counter_clock_o = enable_i & (div1_sel | (div2_sel & prescale) // RULE7
		| (type_a_sel & type_a_timer_clock_i) | (event_sel & event_tick_i)); // RULE9

endmodule
`default_nettype wire
